// >>> opp_pkg.sv
// Package of constants for the program-ROM programming port.
package opp_pkg;
  // Array geometry.
  localparam int unsigned ARRAY_DEPTH = 16384;
  localparam int unsigned ADDR_WIDTH = 15;
  localparam int unsigned DATA_WIDTH = 8;
  // Address field positions within the assembled address.
  localparam int unsigned ADDR_LOW_LSB = 0;
  localparam int unsigned ADDR_BIT_EIGHT = 8;
  localparam int unsigned ADDR_BIT_NINE = 9;
  localparam int unsigned ADDR_UPPER_LSB = 10;
  localparam int unsigned ADDR_TOP_BIT = 14;
  // Value of an unwritten (erased) byte.
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Strobe-decoded operating modes.
  typedef enum logic [2:0] {
    OPP_IDLE,
    OPP_WRITE,
    OPP_VERIFY,
    OPP_INHIBIT,
    OPP_READ,
    OPP_OUT_OFF,
    OPP_STANDBY
  } opp_mode_e;
endpackage : opp_pkg

// >>> opp_array.sv
// Byte-wide program array with one write port and one registered read port.
`timescale 1ns/1ps
module opp_array #(
  parameter int unsigned DEPTH = opp_pkg::ARRAY_DEPTH,
  parameter int unsigned AW = 14
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  // The storage itself; no reset so it maps onto memory.
  logic [7:0] mem [DEPTH];

  // Refuse at elaboration a depth that the address bus cannot reach.
  if (DEPTH > (1 << AW)) begin : g_depth_check
    $error("Array depth exceeds address range.");
  end

  // Write a byte on request; always read the addressed byte a cycle later.
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule : opp_array

// >>> opp_program_port.sv
// Programming-mode port of the one-time-programmable program ROM.
`timescale 1ns/1ps
// Overview of operation
// - Strobes honoured only while reset pin held low.
// - Enter only with boot select zero high, one low.
// - Address from ports A, F and NMI; data port D.
// - High voltage: write, verify, inhibit decode; top bit low.
// - Array holds 16384 bytes, byte programmable.
// - Standby pin acts as programming voltage input.
module opp_program_port #(
  parameter int unsigned DEPTH = opp_pkg::ARRAY_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reset_pin,
  input wire logic boot_select_zero,
  input wire logic boot_select_one,
  input wire logic [7:0] port_a_pins,
  input wire logic port_f_bit_zero,
  input wire logic nmi_pin,
  input wire logic [4:0] port_f_upper_pins,
  input wire logic [7:0] port_d_pins_in,
  output logic [7:0] port_d_pins_out,
  output logic port_d_pins_oe,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic prog_voltage_high,
  output logic prog_mode,
  output logic write_fault
);
  // Array address width; the top pin bit lies above it and never reaches the array.
  localparam int unsigned AW = $clog2(DEPTH);

  // The pin map has room for exactly one depth, so any other value is refused.
  if (DEPTH != opp_pkg::ARRAY_DEPTH) begin : g_depth_check
    $error("Array depth must be 16384.");
  end

  // Assembled address; bit 14 must stay low for a write to reach the array.
  logic [opp_pkg::ADDR_WIDTH-1:0] addr;
  // Array read data.
  logic [7:0] rd_data;
  // Current strobe-decoded mode and its next value.
  opp_pkg::opp_mode_e mode;
  opp_pkg::opp_mode_e next_mode;
  // One-cycle write enable into the array.
  logic wr_pulse;
  // Previous write-decode level, to turn a held pulse into one store.
  logic wr_level_q;
  // High while the reset pin and boot selects ask for programming mode.
  logic mode_ok;

  // True for the strobe pattern that stores a byte.
  function automatic logic is_write(input opp_pkg::opp_mode_e m);
    return m == opp_pkg::OPP_WRITE;
  endfunction : is_write

  // Address is gathered straight from the repurposed pins.
  assign addr = {port_f_upper_pins, nmi_pin, port_f_bit_zero, port_a_pins};
  // Programming mode needs reset low and the boot select pattern.
  assign mode_ok = !reset_pin && boot_select_zero && !boot_select_one;

  // Decode the strobes; the voltage qualifier picks the decode table.
  always_comb begin
    next_mode = opp_pkg::OPP_IDLE;
    if (mode_ok) begin
      if (prog_voltage_high) begin
        unique case ({chip_select_n, output_gate_n})
          2'b01: next_mode = opp_pkg::OPP_WRITE;
          2'b10: next_mode = opp_pkg::OPP_VERIFY;
          2'b11: next_mode = opp_pkg::OPP_INHIBIT;
          // Both low is forbidden for the writer; treat it as inhibit.
          2'b00: next_mode = opp_pkg::OPP_INHIBIT;
        endcase
      end else begin
        unique case ({chip_select_n, output_gate_n})
          2'b00: next_mode = opp_pkg::OPP_READ;
          2'b01: next_mode = opp_pkg::OPP_OUT_OFF;
          2'b10, 2'b11: next_mode = opp_pkg::OPP_STANDBY;
        endcase
      end
    end
  end

  // Registered mode and mode flag.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= opp_pkg::OPP_IDLE;
      prog_mode <= 1'b0;
    end else begin
      mode <= next_mode;
      prog_mode <= mode_ok;
    end
  end

  // A write is stored once, on the first cycle of the write level, so a
  // millisecond pulse does not rewrite the byte thousands of times.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_level_q <= 1'b0;
    end else begin
      wr_level_q <= is_write(next_mode);
    end
  end
  assign wr_pulse = is_write(next_mode) && !wr_level_q
    && !addr[opp_pkg::ADDR_TOP_BIT];

  // Flag a write attempted with the top address bit high; it is dropped.
  // The flag holds between writes so the writer can look at it at leisure.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_fault <= 1'b0;
    end else if (is_write(next_mode)) begin
      write_fault <= addr[opp_pkg::ADDR_TOP_BIT];
    end
  end

  opp_array #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_array (
    .sys_clk(sys_clk),
    .wr_en(wr_pulse),
    .addr(addr[AW-1:0]),
    .wr_data(port_d_pins_in),
    .rd_data(rd_data)
  );

  // Drive data in verify and read; the array output is one cycle late,
  // so data and enable are registered here together with the mode.
  // The price is a two-edge latency after every strobe or address change,
  // which is far inside the writer's access time.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_d_pins_oe <= 1'b0;
      port_d_pins_out <= 8'h00;
    end else begin
      port_d_pins_oe <= (mode == opp_pkg::OPP_VERIFY) || (mode == opp_pkg::OPP_READ);
      port_d_pins_out <= rd_data;
    end
  end

  // Assertions.
  // Outside programming mode the data port must fall quiet within two edges.
  property p_no_drive_outside;
    @(posedge sys_clk) disable iff (!rst_n)
      (reset_pin || !boot_select_zero || boot_select_one) |-> ##2 !port_d_pins_oe;
  endproperty
  a_no_drive_outside: assert property (p_no_drive_outside) else $error("Data driven outside mode.");

  // The mode flag follows the pin pattern one edge later.
  property p_mode_flag;
    @(posedge sys_clk) disable iff (!rst_n)
      (!reset_pin && boot_select_zero && !boot_select_one) |=> prog_mode;
  endproperty
  a_mode_flag: assert property (p_mode_flag) else $error("Mode flag not set.");

  // Raising the reset pin or breaking the boot pattern must drop the flag.
  property p_mode_leave;
    @(posedge sys_clk) disable iff (!rst_n)
      (reset_pin || !boot_select_zero || boot_select_one) |=> !prog_mode;
  endproperty
  a_mode_leave: assert property (p_mode_leave) else $error("Mode flag not cleared.");

  // A held verify pattern must turn the data drivers on.
  property p_verify_drives;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode_ok && prog_voltage_high && chip_select_n && !output_gate_n) [*2] |=> port_d_pins_oe;
  endproperty
  a_verify_drives: assert property (p_verify_drives) else $error("Verify not driving.");

  // While the writer owns the data port the device must not drive it.
  property p_write_no_drive;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode_ok && prog_voltage_high && !chip_select_n) [*2] |=> !port_d_pins_oe;
  endproperty
  a_write_no_drive: assert property (p_write_no_drive) else $error("Driving during write.");

  // A held read pattern must turn the data drivers on.
  property p_read_drives;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode_ok && !prog_voltage_high && !chip_select_n && !output_gate_n) [*2] |=> port_d_pins_oe;
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("Read not driving.");

  // Chip-select high at normal voltage keeps the port quiet.
  property p_standby_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode_ok && !prog_voltage_high && chip_select_n) [*2] |=> !port_d_pins_oe;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("Driving in standby.");

  // A long write pulse must store the byte only once.
  property p_single_store;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_pulse |=> !wr_pulse;
  endproperty
  a_single_store: assert property (p_single_store) else $error("Repeated store.");

  // No store may happen while the top address bit is high.
  property p_top_bit_blocks;
    @(posedge sys_clk) disable iff (!rst_n)
      addr[opp_pkg::ADDR_TOP_BIT] |-> !wr_pulse;
  endproperty
  a_top_bit_blocks: assert property (p_top_bit_blocks) else $error("Store with top bit high.");

  // Output data must be the array word fetched one edge earlier.
  property p_read_data;
    @(posedge sys_clk) disable iff (!rst_n)
      (next_mode == opp_pkg::OPP_READ) ##1 (next_mode == opp_pkg::OPP_READ) && $stable(addr)
        |=> port_d_pins_out == $past(rd_data);
  endproperty
  a_read_data: assert property (p_read_data) else $error("Read data mismatch.");

  // Main scenarios that the bench is expected to reach.
  c_write: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_pulse);
  c_standby: cover property (@(posedge sys_clk) disable iff (!rst_n) mode == opp_pkg::OPP_STANDBY);
  c_verify: cover property (@(posedge sys_clk) disable iff (!rst_n) mode == opp_pkg::OPP_VERIFY ##1 port_d_pins_oe);
  c_read: cover property (@(posedge sys_clk) disable iff (!rst_n) mode == opp_pkg::OPP_READ ##1 port_d_pins_oe);
  c_fault: cover property (@(posedge sys_clk) disable iff (!rst_n) write_fault);
endmodule : opp_program_port

// >>> opp_writer.sv
// Writer-side model of the shared data port of the programming interface.
`timescale 1ns/1ps
module opp_writer (
  input wire logic sys_clk,
  input wire logic [7:0] wdata,
  input wire logic wdrive,
  input wire logic [7:0] dev_data,
  input wire logic dev_oe,
  output logic [7:0] bus
);
  // Last resolved level, kept to fake a floating bus.
  logic [7:0] last = 8'h00;
  always @(posedge sys_clk) last <= bus;
  // An undriven bus shows the inverse of its last level, so stale data never passes.
  always_comb bus = wdrive ? wdata : (dev_oe ? dev_data : ~last);
endmodule : opp_writer

// >>> tb.sv
// Self-checking testbench for the program-ROM programming port.
`timescale 1ns/1ps
module tb;
  logic sys_clk = 0, rst_n = 0, rpin = 0, bs0 = 1, bs1 = 0, nmi = 0, pf0 = 0, wdrive = 0;
  logic cs_n = 1, og_n = 1, vpp = 1, oe, pmode, wfault, oe_q = 0;
  logic [7:0] pa = 0, din = 0, dout, pd_in;
  logic [4:0] pfu = 0;
  logic [7:0] mem [int];
  logic [7:0] expq [$];
  logic [14:0] a;
  int n_fail = 0, tests_run = 0;
  always #25 sys_clk = ~sys_clk;
  opp_writer opp_writer_inst (.sys_clk(sys_clk), .wdata(din), .wdrive(wdrive), .dev_data(dout),
    .dev_oe(oe), .bus(pd_in));
  opp_program_port opp_program_port_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reset_pin(rpin),
    .boot_select_zero(bs0), .boot_select_one(bs1), .port_a_pins(pa), .port_f_bit_zero(pf0),
    .nmi_pin(nmi), .port_f_upper_pins(pfu), .port_d_pins_in(pd_in), .port_d_pins_out(dout),
    .port_d_pins_oe(oe), .chip_select_n(cs_n), .output_gate_n(og_n), .prog_voltage_high(vpp),
    .prog_mode(pmode), .write_fault(wfault));
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // One store edge, then the strobe leaves write decode; ok says programming mode is on, so the write lands unless bit 14 is high.
  task automatic wr(input logic [14:0] ad, input logic [7:0] d, input logic ok);
    {pfu, nmi, pf0, pa} = ad;
    din = d;
    wdrive = 1;
    vpp = 1;
    cs_n = 0;
    cyc(1);
    cs_n = 1;
    wdrive = 0;
    if (ok && !ad[14]) mem[ad[13:0]] = d;
    cyc(1);
    chk("write_fault", 8'(ok & ad[14]), 8'(wfault));
  endtask : wr
  // Holds one strobe pattern for three cycles; never both low under high voltage.
  task automatic strobe(input logic c, input logic g, input logic hv, input logic exp_oe);
    vpp = hv;
    cs_n = c;
    og_n = g;
    if (exp_oe) expq.push_back(mem[{pfu[3:0], nmi, pf0, pa}]);
    cyc(3);
    chk("port_d_pins_oe", 8'(exp_oe), 8'(oe));
    cs_n = 1;
    og_n = 1;
    cyc(3);
    chk("port_d_pins_oe idle", 8'h00, 8'(oe));
  endtask : strobe
  // Each rise of the output enable carries the oldest noted byte.
  always @(negedge sys_clk) begin
    oe_q <= oe;
    if (oe === 1'b1 && oe_q !== 1'b1) chk("port_d_pins_out", expq.size() ? expq.pop_front() : ~dout, dout);
  end
  initial begin
    #200us;
    n_fail++;
    test_done();
  end
  initial begin
    void'($urandom(32'h0000_4763));
    cyc(5);
    rst_n = 1;
    cyc(2);
    chk("prog_mode", 8'h01, 8'(pmode));
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h3FFF : {1'b0, 14'($urandom)};
      wr(a, 8'($urandom), 1);
      strobe(1, 0, 1, 1);
      wr(a, mem[a[13:0]], 1);
      strobe(0, 0, 0, 1);
    end
    wr(a | 15'h4000, ~mem[a[13:0]], 1);
    strobe(0, 0, 0, 1);
    strobe(1, 0, 1, 1);
    wr(a, 8'($urandom), 1);
    strobe(0, 1, 0, 0);
    strobe(1, 0, 0, 0);
    strobe(1, 1, 0, 0);
    strobe(1, 1, 1, 0);
    rpin = 1;
    cyc(2);
    chk("prog_mode", 8'h00, 8'(pmode));
    wr(a, ~mem[a[13:0]], 0);
    strobe(0, 0, 0, 0);
    rpin = 0;
    bs1 = 1;
    cyc(2);
    chk("prog_mode", 8'h00, 8'(pmode));
    strobe(1, 0, 1, 0);
    bs1 = 0;
    cyc(2);
    strobe(0, 0, 0, 1);
    chk("pending results", 8'h00, 8'(expq.size()));
    test_done();
  end
endmodule : tb
